/* rtl/tcc_pkg.sv */
// register map, field positions and encodings of the capture/compare block
package tcc_pkg;
  // register byte offsets, one aligned word each, data in bits 7:0
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CAP1_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CAP1_LOW = 8'h10;
  localparam logic [7:0] OFS_CAP2_HIGH = 8'h14;
  localparam logic [7:0] OFS_CAP2_LOW = 8'h18;
  localparam logic [7:0] OFS_CMP1_HIGH = 8'h1C;
  localparam logic [7:0] OFS_CMP1_LOW = 8'h20;
  localparam logic [7:0] OFS_CMP2_HIGH = 8'h24;
  localparam logic [7:0] OFS_CMP2_LOW = 8'h28;
  // timer_control_one fields
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_FORCE2 = 4;
  localparam int C1_FORCE1 = 3;
  localparam int C1_LEVEL2 = 2;
  localparam int C1_EDGE1 = 1;
  localparam int C1_LEVEL1 = 0;
  // timer_control_two fields
  localparam int C2_OE1 = 7;
  localparam int C2_OE2 = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE2 = 1;
  localparam int C2_EXT_EDGE = 0;
  // timer_status_register fields
  localparam int ST_CAP1 = 7;
  localparam int ST_CMP1 = 6;
  localparam int ST_CAP2 = 4;
  localparam int ST_CMP2 = 3;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'h8000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  // value the counter core loads on a preset request
  localparam logic [15:0] PRESET_VALUE = 16'hFFFC;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CLK_DIV4 = 2'b00,
    CLK_DIV2 = 2'b01,
    CLK_DIV8 = 2'b10,
    CLK_EXT = 2'b11
  } clock_select_t;
endpackage : tcc_pkg

/* rtl/timer_capture_compare_pwm.sv */
// capture, compare, forced compare, one-pulse and pwm logic with axi4-lite
//
// Behaviour
// - two 16-bit captures copy counter on edge
// - per-input edge select bit in software
// - select 0 falling, 1 rising edge
// - capture sets flag; interrupt if enabled, unmasked
// - flag clears: status read, then low-byte access
// - high byte read blocks capture until low
// - capture register holds most recent event; in halt the code keeps the first edge
// - halt arms capture; flag appears on wake
// - compare registers matched each tick, flag set
// - compare registers software only, reset 8000h
// - match with enable drives level; pin resets low
// - compare match interrupts if enabled, unmasked
// - compare flag clears: status read, low access
// - high byte write disables compare until low
// - enable clear: pin untouched, interrupt still possible
// - divide by two: match at counter equal
// - other clocks: match at value plus one
// - force bit copies level, no flag
// - one-pulse: edge presets counter, drives level two
// - one-pulse: no compare flag one; capture flag
// - both mode bits set means pwm only
// - pwm: match one level one, two level two
// - pulse length is compare two minus one
// - compare two match in pwm presets counter
// - pwm: compare flags off, capture flag on period
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module timer_capture_compare_pwm
  import tcc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] counter_value,
  input wire logic timer_tick,
  input wire logic halt_mode,
  input wire logic global_mask,
  input wire logic [1:0] capture_pin,
  output logic [1:0] compare_pin_out,
  output logic [1:0] compare_pin_oe_n,
  output logic counter_preset,
  output logic timer_irq
);

  if (ADDR_W < 8) begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  // ---------------- axi4-lite slave ----------------
  logic [ADDR_W-1:0] w_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire do_read = s_axi_arvalid && s_axi_arready;

  wire wr_ctrl1 = do_write && w_addr == ADDR_W'(OFS_CTRL_ONE);
  wire wr_ctrl2 = do_write && w_addr == ADDR_W'(OFS_CTRL_TWO);
  wire wr_status = do_write && w_addr == ADDR_W'(OFS_STATUS);
  wire wr_cap1h = do_write && w_addr == ADDR_W'(OFS_CAP1_HIGH);
  wire wr_cap1l = do_write && w_addr == ADDR_W'(OFS_CAP1_LOW);
  wire wr_cap2h = do_write && w_addr == ADDR_W'(OFS_CAP2_HIGH);
  wire wr_cap2l = do_write && w_addr == ADDR_W'(OFS_CAP2_LOW);
  wire wr_cmp1h = do_write && w_addr == ADDR_W'(OFS_CMP1_HIGH);
  wire wr_cmp1l = do_write && w_addr == ADDR_W'(OFS_CMP1_LOW);
  wire wr_cmp2h = do_write && w_addr == ADDR_W'(OFS_CMP2_HIGH);
  wire wr_cmp2l = do_write && w_addr == ADDR_W'(OFS_CMP2_LOW);
  wire wr_mapped = wr_ctrl1 | wr_ctrl2 | wr_status | wr_cap1h | wr_cap1l |
                   wr_cap2h | wr_cap2l | wr_cmp1h | wr_cmp1l | wr_cmp2h |
                   wr_cmp2l;

  wire rd_ctrl1 = do_read && s_axi_araddr == ADDR_W'(OFS_CTRL_ONE);
  wire rd_ctrl2 = do_read && s_axi_araddr == ADDR_W'(OFS_CTRL_TWO);
  wire rd_status = do_read && s_axi_araddr == ADDR_W'(OFS_STATUS);
  wire rd_cap1h = do_read && s_axi_araddr == ADDR_W'(OFS_CAP1_HIGH);
  wire rd_cap1l = do_read && s_axi_araddr == ADDR_W'(OFS_CAP1_LOW);
  wire rd_cap2h = do_read && s_axi_araddr == ADDR_W'(OFS_CAP2_HIGH);
  wire rd_cap2l = do_read && s_axi_araddr == ADDR_W'(OFS_CAP2_LOW);
  wire rd_cmp1h = do_read && s_axi_araddr == ADDR_W'(OFS_CMP1_HIGH);
  wire rd_cmp1l = do_read && s_axi_araddr == ADDR_W'(OFS_CMP1_LOW);
  wire rd_cmp2h = do_read && s_axi_araddr == ADDR_W'(OFS_CMP2_HIGH);
  wire rd_cmp2l = do_read && s_axi_araddr == ADDR_W'(OFS_CMP2_LOW);
  wire rd_mapped = rd_ctrl1 | rd_ctrl2 | rd_status | rd_cap1h | rd_cap1l |
                   rd_cap2h | rd_cap2l | rd_cmp1h | rd_cmp1l | rd_cmp2h |
                   rd_cmp2l;

  // a write strobe without lane 0 changes no register data but still counts
  // as an access to the register for flag clearing and compare arming
  wire wr_data_ok = w_lane0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      w_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        w_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------- control registers ----------------
  logic [7:0] timer_control_one;
  logic [7:0] timer_control_two;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_one <= CTRL_RESET;
      timer_control_two <= CTRL_RESET;
    end else begin
      if (wr_ctrl1 && wr_data_ok) timer_control_one <= w_byte;
      if (wr_ctrl2 && wr_data_ok) timer_control_two <= w_byte;
    end
  end

  wire [1:0] edge_select = {timer_control_two[C2_EDGE2],
                            timer_control_one[C1_EDGE1]};
  wire [1:0] output_level = {timer_control_one[C1_LEVEL2],
                             timer_control_one[C1_LEVEL1]};
  wire [1:0] force_output = {timer_control_one[C1_FORCE2],
                             timer_control_one[C1_FORCE1]};
  wire [1:0] compare_output_enable = {timer_control_two[C2_OE2],
                                      timer_control_two[C2_OE1]};
  wire capture_interrupt_enable = timer_control_one[C1_CAP_IE];
  wire compare_interrupt_enable = timer_control_one[C1_CMP_IE];
  wire pwm_on = timer_control_two[C2_PWM];
  wire one_pulse_on = timer_control_two[C2_ONE_PULSE] && !pwm_on;
  wire div2_clock = timer_control_two[C2_CLK_HI:C2_CLK_LO] == CLK_DIV2;

  // ---------------- capture edge detection ----------------
  logic [1:0] pin_prev;
  logic pin_valid;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev <= 2'b00;
      pin_valid <= 1'b0;
    end else begin
      pin_prev <= capture_pin;
      pin_valid <= 1'b1;
    end
  end

  // first cycle after reset has no history, so no edge is taken
  wire [1:0] rise = capture_pin & ~pin_prev;
  wire [1:0] fall = ~capture_pin & pin_prev;
  wire [1:0] active_edge = pin_valid ?
    ((rise & edge_select) | (fall & ~edge_select)) : 2'b00;
  // channel 1 capture is taken over by the pwm period in pwm mode
  wire [1:0] capture_event = active_edge & {1'b1, !pwm_on};

  // ---------------- compare match ----------------
  logic [15:0] compare_value [2];
  logic [1:0] compare_armed;
  logic [1:0] compare_match;
  wire [1:0] wr_cmp_high = {wr_cmp2h, wr_cmp1h};
  wire [1:0] wr_cmp_low = {wr_cmp2l, wr_cmp1l};
  wire [1:0] rd_cmp_low = {rd_cmp2l, rd_cmp1l};
  wire [1:0] rd_cap_high = {rd_cap2h, rd_cap1h};
  wire [1:0] rd_cap_low = {rd_cap2l, rd_cap1l};
  wire [1:0] wr_cap_low = {wr_cap2l, wr_cap1l};

  wire pwm_period_hit = pwm_on && compare_match[1];

  // ---------------- per-channel capture and compare ----------------
  logic [15:0] capture_value [2];
  logic [1:0] capture_lock;
  logic [1:0] halt_armed;
  logic [1:0] capture_flag;
  logic [1:0] capture_seen;
  logic [1:0] compare_flag;
  logic [1:0] compare_seen;
  logic [1:0] capture_flag_set;
  logic [1:0] compare_flag_set;

  // a pwm period end sets capture flag 1 without new data
  assign capture_flag_set[0] = (capture_event[0] && !halt_mode) ||
    (halt_armed[0] && !halt_mode) || pwm_period_hit;
  assign capture_flag_set[1] = (capture_event[1] && !halt_mode) ||
    (halt_armed[1] && !halt_mode);
  assign compare_flag_set[0] = compare_match[0] && !pwm_on &&
    !one_pulse_on;
  assign compare_flag_set[1] = compare_match[1] && !pwm_on;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // div 2 matches on counter equal, slower clocks one count later
      wire [15:0] match_target = div2_clock ? compare_value[ch] :
        16'(compare_value[ch] + 16'h0001);
      assign compare_match[ch] = timer_tick && compare_armed[ch] &&
        counter_value == match_target;
      wire take = capture_event[ch] && !capture_lock[ch] &&
        (!halt_mode || !halt_armed[ch]);
      wire cap_low_access = rd_cap_low[ch] || wr_cap_low[ch];
      wire cap_clear = capture_seen[ch] && cap_low_access;
      wire cmp_low_access = rd_cmp_low[ch] || wr_cmp_low[ch];
      wire cmp_clear = compare_seen[ch] && cmp_low_access;

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          capture_value[ch] <= CAPTURE_RESET;
          capture_lock[ch] <= 1'b0;
          halt_armed[ch] <= 1'b0;
        end else begin
          if (take) capture_value[ch] <= counter_value;
          if (rd_cap_high[ch]) capture_lock[ch] <= 1'b1;
          else if (rd_cap_low[ch]) capture_lock[ch] <= 1'b0;
          if (take && halt_mode) halt_armed[ch] <= 1'b1;
          else if (!halt_mode) halt_armed[ch] <= 1'b0;
        end
      end

      // set wins over a clear arriving in the same cycle
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          capture_flag[ch] <= 1'b0;
          capture_seen[ch] <= 1'b0;
          compare_flag[ch] <= 1'b0;
          compare_seen[ch] <= 1'b0;
        end else begin
          capture_flag[ch] <= capture_flag_set[ch] ||
            (capture_flag[ch] && !cap_clear);
          if (cap_clear || capture_flag_set[ch]) capture_seen[ch] <= 1'b0;
          else if (rd_status && capture_flag[ch]) capture_seen[ch] <= 1'b1;
          compare_flag[ch] <= compare_flag_set[ch] ||
            (compare_flag[ch] && !cmp_clear);
          if (cmp_clear || compare_flag_set[ch]) compare_seen[ch] <= 1'b0;
          else if (rd_status && compare_flag[ch]) compare_seen[ch] <= 1'b1;
        end
      end

      // the timer never writes these; only software does
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          compare_value[ch] <= COMPARE_RESET;
          compare_armed[ch] <= 1'b1;
        end else begin
          if (wr_cmp_high[ch]) begin
            if (wr_data_ok) compare_value[ch][15:8] <= w_byte;
            compare_armed[ch] <= 1'b0;
          end
          if (wr_cmp_low[ch]) begin
            if (wr_data_ok) compare_value[ch][7:0] <= w_byte;
            compare_armed[ch] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ---------------- compare pins ----------------
  logic [1:0] next_pin;
  always_comb begin
    next_pin = compare_pin_out;
    // pin 1: forced level beats mode logic
    if (force_output[0] && compare_output_enable[0]) begin
      next_pin[0] = output_level[0];
    end else if (compare_output_enable[0]) begin
      if (pwm_on) begin
        if (compare_match[0]) next_pin[0] = output_level[0];
        if (compare_match[1]) next_pin[0] = output_level[1];
      end else if (one_pulse_on) begin
        if (capture_event[0] && !halt_mode)
          next_pin[0] = output_level[1];
        if (compare_match[0]) next_pin[0] = output_level[0];
      end else if (compare_match[0]) begin
        next_pin[0] = output_level[0];
      end
    end
    // pin 2 keeps normal compare behaviour except in pwm, where matches leave it; disabled pin is left alone
    if (force_output[1] && compare_output_enable[1]) begin
      next_pin[1] = output_level[1];
    end else if (compare_output_enable[1] && compare_match[1] && !pwm_on) begin
      next_pin[1] = output_level[1];
    end
  end

  // pin latches start low; oe_n high leaves the pin to general i/o
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      compare_pin_out <= 2'b00;
      compare_pin_oe_n <= 2'b11;
      counter_preset <= 1'b0;
    end else begin
      compare_pin_out <= next_pin;
      compare_pin_oe_n <= ~compare_output_enable;
      counter_preset <= pwm_period_hit ||
        (one_pulse_on && capture_event[0] && !halt_mode);
    end
  end

  // ---------------- interrupt request ----------------
  wire irq_cause = (capture_interrupt_enable && |capture_flag) ||
                   (compare_interrupt_enable && |compare_flag);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) timer_irq <= 1'b0;
    else timer_irq <= irq_cause && !global_mask;
  end

  // ---------------- read data ----------------
  wire [7:0] status_byte = {capture_flag[0], compare_flag[0], 1'b0,
                            capture_flag[1], compare_flag[1], 3'b000};
  wire [7:0] rd_byte =
    rd_ctrl1 ? timer_control_one :
    rd_ctrl2 ? timer_control_two :
    rd_status ? status_byte :
    rd_cap1h ? capture_value[0][15:8] :
    rd_cap1l ? capture_value[0][7:0] :
    rd_cap2h ? capture_value[1][15:8] :
    rd_cap2l ? capture_value[1][7:0] :
    rd_cmp1h ? compare_value[0][15:8] :
    rd_cmp1l ? compare_value[0][7:0] :
    rd_cmp2h ? compare_value[1][15:8] :
    rd_cmp2l ? compare_value[1][7:0] : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : timer_capture_compare_pwm

/* test/counter_model.sv */
// free-running counter core stand-in with tick and preset load
`timescale 1ns/1ps
module counter_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [3:0] period,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic counter_preset,
  output logic [15:0] counter_value,
  output logic timer_tick
);
  logic [15:0] count;
  logic [3:0] phase;
  assign counter_value = count;
  // a preset request beats a bench load; loads restart the prescaler
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      phase <= 4'h0;
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= 1'b0;
      if (counter_preset) begin
        count <= 16'hFFFC;
        phase <= 4'h0;
      end else if (load) begin
        count <= load_value;
        phase <= 4'h0;
      end else if (run) begin
        phase <= (phase + 4'h1 >= period) ? 4'h0 : phase + 4'h1;
        if (phase + 4'h1 >= period) begin
          count <= count + 16'h0001;
          timer_tick <= 1'b1;
        end
      end
    end
  end
endmodule : counter_model

/* test/tcc_assertions.sv */
// port-level checks on the capture/compare block
`timescale 1ns/1ps
module tcc_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic global_mask,
  input wire logic [1:0] compare_pin_out,
  input wire logic [1:0] compare_pin_oe_n,
  input wire logic counter_preset,
  input wire logic timer_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_write_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_byte_data: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_mask_irq: assert property (global_mask |=> !timer_irq)
    else $error("irq raised while masked");
  a_preset_pulse: assert property (
    counter_preset |=> !counter_preset)
    else $error("preset longer than one cycle");
  a_pin_one_off: assert property (
    compare_pin_oe_n[0] |=> $stable(compare_pin_out[0]))
    else $error("pin one latch moved while disabled");
  a_pin_two_off: assert property (
    compare_pin_oe_n[1] |=> $stable(compare_pin_out[1]))
    else $error("pin two latch moved while disabled");
endmodule : tcc_assertions

/* test/testbench.sv */
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
module testbench import tcc_pkg::*;;
  logic mclk = 1'b0, rst_n = 1'b0, global_mask = 1'b0, halt_mode = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run = 1'b0, load = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, rdat, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, period = 4'h2;
  logic [1:0] capture_pin = 2'h2, s_axi_bresp, s_axi_rresp, resp;
  logic [1:0] compare_pin_out, compare_pin_oe_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, counter_preset, timer_irq, timer_tick;
  logic [15:0] counter_value, load_value = 16'h0000;
  int fails = 0, tests_run = 0;

  always #5 mclk = ~mclk;

  timer_capture_compare_pwm u_timer_capture_compare_pwm (.mclk, .rst_n,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .counter_value, .timer_tick, .halt_mode,
    .global_mask, .capture_pin, .compare_pin_out, .compare_pin_oe_n,
    .counter_preset, .timer_irq);
  counter_model u_counter_model (.mclk, .rst_n, .run, .period, .load,
    .load_value, .counter_preset, .counter_value, .timer_tick);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask : rchk

  // counter is loaded only while stopped so capture values are exact
  task automatic load_count(input logic [15:0] c);
    @(posedge mclk);
    load_value <= c;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
  endtask : load_count

  task automatic pin(input int i, input logic v, input logic [15:0] c);
    load_count(c);
    capture_pin[i] <= v;
    repeat (3) @(posedge mclk);
  endtask : pin

  task automatic wait_pin(input logic v);
    while (compare_pin_out[0] !== v) @(posedge mclk);
  endtask : wait_pin

  task automatic t_reset();
    chk({28'h0, compare_pin_oe_n, compare_pin_out}, 32'hC);
    rchk(OFS_CMP1_HIGH, 32'h80);
    rchk(OFS_CMP2_LOW, 32'h00);
    rchk(OFS_STATUS, 32'h00);
    rd(8'h2C);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h2C, 8'h00);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_CMP2_HIGH, 8'h5A);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    rchk(OFS_CMP2_HIGH, 32'h5A);
  endtask : t_reset

  task automatic t_capture();
    wr(OFS_CTRL_ONE, 8'h82);
    pin(0, 1'b1, 16'h1234);
    chk({31'h0, timer_irq}, 32'h1);
    global_mask <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, timer_irq}, 32'h0);
    global_mask <= 1'b0;
    rchk(OFS_STATUS, 32'h80);
    rchk(OFS_CAP1_HIGH, 32'h12);
    rchk(OFS_CAP1_LOW, 32'h34);
    rchk(OFS_STATUS, 32'h00);
    pin(0, 1'b0, 16'h1111);
    rchk(OFS_STATUS, 32'h00);
    rchk(OFS_CAP1_HIGH, 32'h12);
    pin(0, 1'b1, 16'h5678);
    rchk(OFS_CAP1_LOW, 32'h34);
    pin(0, 1'b0, 16'h9ABC);
    pin(0, 1'b1, 16'h9ABC);
    rchk(OFS_CAP1_HIGH, 32'h9A);
    rchk(OFS_CAP1_LOW, 32'hBC);
    pin(1, 1'b0, 16'h4321);
    rchk(OFS_STATUS, 32'h90);
    rchk(OFS_CAP2_HIGH, 32'h43);
    rchk(OFS_CAP2_LOW, 32'h21);
    wr(OFS_CAP1_LOW, 8'h00);
    rchk(OFS_STATUS, 32'h00);
    // halted: first falling edge on channel 2 is kept, the second dropped
    halt_mode <= 1'b1;
    pin(1, 1'b1, 16'h0666);
    pin(1, 1'b0, 16'h0777);
    rchk(OFS_STATUS, 32'h00);
    pin(1, 1'b1, 16'h0666);
    pin(1, 1'b0, 16'h0888);
    halt_mode <= 1'b0;
    rchk(OFS_STATUS, 32'h10);
    rchk(OFS_CAP2_HIGH, 32'h07);
    rchk(OFS_CAP2_LOW, 32'h77);
    wr(OFS_CTRL_ONE, 8'h00);
  endtask : t_capture

  task automatic t_compare();
    logic lvl;
    for (int i = 0; i < 4; i++) begin
      lvl = ~i[0];
      wr(OFS_CTRL_TWO, {4'h8, 2'(i), 2'h0});
      wr(OFS_CTRL_ONE, {7'h20, lvl});
      wr(OFS_CMP1_HIGH, 8'h01);
      wr(OFS_CMP1_LOW, 8'h00);
      load_count(16'h00F8);
      period <= (i == 1) ? 4'h2 : (i == 2) ? 4'h8 : 4'h4;
      run <= 1'b1;
      wait_pin(lvl);
      chk({16'h0, counter_value}, (i == 1) ? 32'h100 : 32'h101);
      run <= 1'b0;
      rchk(OFS_STATUS, 32'h40);
      chk({31'h0, timer_irq}, 32'h1);
      wr(OFS_CMP1_LOW, 8'h00);
      repeat (2) @(posedge mclk);
      chk({31'h0, timer_irq}, 32'h0);
    end
  endtask : t_compare

  task automatic t_force();
    wr(OFS_CTRL_TWO, 8'h40);
    wr(OFS_CTRL_ONE, 8'h14);
    repeat (2) @(posedge mclk);
    chk({28'h0, compare_pin_oe_n, compare_pin_out}, 32'h6);
    rchk(OFS_STATUS, 32'h00);
    wr(OFS_CTRL_ONE, 8'h00);
  endtask : t_force

  task automatic t_pwm();
    int n;
    wr(OFS_CMP1_HIGH, 8'h00);
    wr(OFS_CMP1_LOW, 8'h04);
    wr(OFS_CMP2_HIGH, 8'h00);
    rchk(OFS_STATUS, 32'h00);
    wr(OFS_CMP2_LOW, 8'h0A);
    wr(OFS_CTRL_ONE, 8'h01);
    wr(OFS_CTRL_TWO, 8'hB4);
    load_count(16'hFFF0);
    period <= 4'h2;
    run <= 1'b1;
    while (counter_preset !== 1'b1) @(posedge mclk);
    @(posedge mclk);
    chk({16'h0, counter_value}, {16'h0, PRESET_VALUE});
    wait_pin(1'b1);
    n = 0;
    while (compare_pin_out[0] === 1'b1) begin
      n++;
      @(posedge mclk);
    end
    chk(32'(n), 32'd12);
    run <= 1'b0;
    rchk(OFS_STATUS, 32'h80);
    wr(OFS_CAP1_LOW, 8'h00);
  endtask : t_pwm

  task automatic t_one_pulse();
    wr(OFS_CMP1_LOW, 8'h03);
    wr(OFS_CTRL_ONE, 8'h06);
    wr(OFS_CTRL_TWO, 8'hA4);
    pin(0, 1'b0, 16'h1000);
    run <= 1'b1;
    capture_pin[0] <= 1'b1;
    while (counter_preset !== 1'b1) @(posedge mclk);
    @(posedge mclk);
    chk({16'h0, counter_value}, {16'h0, PRESET_VALUE});
    wait_pin(1'b1);
    wait_pin(1'b0);
    chk({16'h0, counter_value}, 32'h3);
    run <= 1'b0;
    rchk(OFS_STATUS, 32'h80);
  endtask : t_one_pulse

  task automatic complete_run();
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_capture();
    t_compare();
    t_force();
    t_pwm();
    t_one_pulse();
    complete_run();
  end

  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run();
  end
endmodule : testbench

bind timer_capture_compare_pwm tcc_assertions u_tcc_assertions (.mclk,
  .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .global_mask, .compare_pin_out, .compare_pin_oe_n,
  .counter_preset, .timer_irq);
